// >>> design/irvm_regs.svh
`ifndef IRVM_REGS_SVH
`define IRVM_REGS_SVH

// Register byte offsets on the Avalon-MM slave.
`define IRVM_ADDR_W        6
`define IRVM_OFS_GLOBAL    6'h00
`define IRVM_OFS_FLAGS     6'h04
`define IRVM_OFS_ENABLE    6'h08
`define IRVM_OFS_MASK      6'h0c
`define IRVM_OFS_VECTOR    6'h10
`define IRVM_OFS_TAKEN     6'h14

// Flag, enable and mask layout, shared by those three registers, plus the global enable bit.
`define IRVM_NSRC          5
`define IRVM_BIT_NMI       0
`define IRVM_BIT_VLM       1
`define IRVM_BIT_OVF       2
`define IRVM_BIT_CMP       3
`define IRVM_BIT_PIT       4
`define IRVM_BIT_GIE       0

// Vector numbers and their word entry addresses.
`define IRVM_VEC_W         3
`define IRVM_WADDR_W       8
`define IRVM_VEC_RESET     3'h0
`define IRVM_VEC_NMI       3'h1
`define IRVM_VEC_VLM       3'h2
`define IRVM_VEC_CNT       3'h3
`define IRVM_VEC_PIT       3'h4
`define IRVM_WADDR_RESET   8'h00
`define IRVM_WADDR_NMI     8'h02
`define IRVM_WADDR_VLM     8'h04
`define IRVM_WADDR_CNT     8'h06
`define IRVM_WADDR_PIT     8'h08

// Vector status register fields.
`define IRVM_VS_VEC_LSB    0
`define IRVM_VS_ADDR_LSB   8
`define IRVM_VS_PEND_BIT   16
`define IRVM_VS_NMI_BIT    17

`define IRVM_RST_GLOBAL    1'h0
`define IRVM_RST_FLAGS     5'h00
`define IRVM_RST_MASK      5'h00

`endif

// >>> design/irvm_pkg.sv
`include "irvm_regs.svh"

package irvm_pkg;

    typedef enum logic [0:0] {
        IRVM_BUS_IDLE   = 1'b0,
        IRVM_BUS_ANSWER = 1'b1
    } irvm_bus_state_t;

    typedef logic [`IRVM_NSRC-1:0] irvm_src_vec_t;

endpackage : irvm_pkg

// >>> design/irvm_src_if.sv
interface irvm_src_if #(
    parameter int W = 1
);
    logic [W-1:0] set_evt;
    logic [W-1:0] clr;
    logic         en_we;
    logic [W-1:0] en_wdata;
    logic [W-1:0] flags;
    logic [W-1:0] en;
    logic [W-1:0] req;

    modport ctl (
        output set_evt,
        output clr,
        output en_we,
        output en_wdata,
        input  flags,
        input  en,
        input  req
    );

    modport src (
        input  set_evt,
        input  clr,
        input  en_we,
        input  en_wdata,
        output flags,
        output en,
        output req
    );
endinterface : irvm_src_if

// >>> design/irvm_source.sv
`include "irvm_regs.svh"

// One peripheral instance: its flags, its enable bits and its request lines.
module irvm_source #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Link to the controller
    irvm_src_if.src  port
);

    logic [W-1:0] flags;
    logic [W-1:0] en;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~port.clr) | port.set_evt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            en <= '0;
        end else if (port.en_we) begin
            en <= port.en_wdata;
        end
    end

    assign port.flags = flags;
    assign port.en    = en;
    assign port.req   = flags & en;

endmodule : irvm_source

// >>> design/irvm_controller.sv
`include "irvm_regs.svh"

module irvm_controller (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    // Avalon-MM slave
    input  wire logic [`IRVM_ADDR_W-1:0]   avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    // Peripheral event pulses
    input  wire logic                      memory_scan_nmi_source,
    input  wire logic                      voltage_level_monitor_source,
    input  wire logic [1:0]                counter_overflow_compare_source,
    input  wire logic                      periodic_timer_source,
    // Processor core side
    input  wire logic                      core_vector_ack,
    output logic                           core_req,
    output logic                           core_nmi,
    output logic [`IRVM_VEC_W-1:0]         core_vector,
    output logic [`IRVM_WADDR_W-1:0]       core_address,
    // Summary interrupt
    output logic                           irq
);

    irvm_pkg::irvm_bus_state_t bus_state;
    irvm_pkg::irvm_bus_state_t next_bus_state;

    logic                      global_en;
    irvm_pkg::irvm_src_vec_t   irq_mask;
    logic [`IRVM_VEC_W-1:0]    taken_vector;

    irvm_pkg::irvm_src_vec_t   all_flags;
    irvm_pkg::irvm_src_vec_t   all_en;
    irvm_pkg::irvm_src_vec_t   all_req;

    logic                      wr_fire;
    logic                      wr_low;
    logic                      hit_flags;
    logic                      hit_enable;
    irvm_pkg::irvm_src_vec_t   clr_bits;
    logic [31:0]               next_readdata;

    logic                      pend_nmi;
    logic                      pend_vlm;
    logic                      pend_cnt;
    logic                      pend_pit;
    logic                      next_req;
    logic                      next_nmi;
    logic [`IRVM_VEC_W-1:0]    next_vector;
    logic [`IRVM_WADDR_W-1:0]  next_address;

    // One link per peripheral instance, each owning its own vector.
    irvm_src_if #(.W(1)) nmi_if ();
    irvm_src_if #(.W(1)) vlm_if ();
    irvm_src_if #(.W(2)) cnt_if ();
    irvm_src_if #(.W(1)) pit_if ();

    irvm_source #(.W(1)) u_nmi (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (nmi_if.src)
    );

    irvm_source #(.W(1)) u_vlm (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (vlm_if.src)
    );

    irvm_source #(.W(2)) u_cnt (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (cnt_if.src)
    );

    irvm_source #(.W(1)) u_pit (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .port    (pit_if.src)
    );

    // Bus decode. A write takes effect only at the edge where waitrequest is low.
    assign wr_fire    = avs_write && (bus_state == irvm_pkg::IRVM_BUS_ANSWER);
    assign wr_low     = wr_fire && avs_byteenable[0];
    assign hit_flags  = (avs_address == `IRVM_OFS_FLAGS);
    assign hit_enable = (avs_address == `IRVM_OFS_ENABLE);
    assign clr_bits   = (wr_low && hit_flags) ? avs_writedata[`IRVM_NSRC-1:0] : '0;

    // Event and clear routing into the peripheral instances.
    assign nmi_if.set_evt  = memory_scan_nmi_source;
    assign vlm_if.set_evt  = voltage_level_monitor_source;
    assign cnt_if.set_evt  = counter_overflow_compare_source;
    assign pit_if.set_evt  = periodic_timer_source;

    assign nmi_if.clr = clr_bits[`IRVM_BIT_NMI];
    assign vlm_if.clr = clr_bits[`IRVM_BIT_VLM];
    assign cnt_if.clr = clr_bits[`IRVM_BIT_CMP:`IRVM_BIT_OVF];
    assign pit_if.clr = clr_bits[`IRVM_BIT_PIT];

    assign nmi_if.en_we = wr_low && hit_enable;
    assign vlm_if.en_we = wr_low && hit_enable;
    assign cnt_if.en_we = wr_low && hit_enable;
    assign pit_if.en_we = wr_low && hit_enable;

    assign nmi_if.en_wdata = avs_writedata[`IRVM_BIT_NMI];
    assign vlm_if.en_wdata = avs_writedata[`IRVM_BIT_VLM];
    assign cnt_if.en_wdata = avs_writedata[`IRVM_BIT_CMP:`IRVM_BIT_OVF];
    assign pit_if.en_wdata = avs_writedata[`IRVM_BIT_PIT];

    assign all_flags = {pit_if.flags, cnt_if.flags, vlm_if.flags, nmi_if.flags};
    assign all_en    = {pit_if.en, cnt_if.en, vlm_if.en, nmi_if.en};
    assign all_req   = {pit_if.req, cnt_if.req, vlm_if.req, nmi_if.req};

    // Bus handshake: every access answers exactly one cycle after it is seen.
    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            irvm_pkg::IRVM_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = irvm_pkg::IRVM_BUS_ANSWER;
                end
            end
            irvm_pkg::IRVM_BUS_ANSWER: begin
                next_bus_state = irvm_pkg::IRVM_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bus_state <= irvm_pkg::IRVM_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(next_bus_state == irvm_pkg::IRVM_BUS_ANSWER);
        end
    end

    // Read data is latched on the edge that enters the answer cycle.
    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            `IRVM_OFS_GLOBAL: begin
                next_readdata[`IRVM_BIT_GIE] = global_en;
            end
            `IRVM_OFS_FLAGS: begin
                next_readdata[`IRVM_NSRC-1:0] = all_flags;
            end
            `IRVM_OFS_ENABLE: begin
                next_readdata[`IRVM_NSRC-1:0] = all_en;
            end
            `IRVM_OFS_MASK: begin
                next_readdata[`IRVM_NSRC-1:0] = irq_mask;
            end
            `IRVM_OFS_VECTOR: begin
                next_readdata[`IRVM_VS_VEC_LSB +: `IRVM_VEC_W]    = core_vector;
                next_readdata[`IRVM_VS_ADDR_LSB +: `IRVM_WADDR_W] = core_address;
                next_readdata[`IRVM_VS_PEND_BIT]                  = core_req;
                next_readdata[`IRVM_VS_NMI_BIT]                   = core_nmi;
            end
            `IRVM_OFS_TAKEN: begin
                next_readdata[`IRVM_VS_VEC_LSB +: `IRVM_VEC_W] = taken_vector;
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_state == irvm_pkg::IRVM_BUS_IDLE) begin
            avs_readdata <= next_readdata;
        end
    end

    // Software-owned control state.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            global_en <= `IRVM_RST_GLOBAL;
        end else if (wr_low && avs_address == `IRVM_OFS_GLOBAL) begin
            global_en <= avs_writedata[`IRVM_BIT_GIE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irq_mask <= `IRVM_RST_MASK;
        end else if (wr_low && avs_address == `IRVM_OFS_MASK) begin
            irq_mask <= avs_writedata[`IRVM_NSRC-1:0];
        end
    end

    // The summary line follows the sticky flags, not the enables, so polling
    // software can use it with every vector enable left clear.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(all_flags & irq_mask);
        end
    end

    // Request qualification and fixed priority.
    assign pend_nmi = nmi_if.req;
    assign pend_vlm = vlm_if.req && global_en;
    assign pend_cnt = (|cnt_if.req) && global_en;
    assign pend_pit = pit_if.req && global_en;

    always_comb begin
        next_req     = 1'b1;
        next_nmi     = 1'b0;
        next_vector  = `IRVM_VEC_RESET;
        next_address = `IRVM_WADDR_RESET;
        if (pend_nmi) begin
            next_nmi     = 1'b1;
            next_vector  = `IRVM_VEC_NMI;
            next_address = `IRVM_WADDR_NMI;
        end else if (pend_vlm) begin
            next_vector  = `IRVM_VEC_VLM;
            next_address = `IRVM_WADDR_VLM;
        end else if (pend_cnt) begin
            next_vector  = `IRVM_VEC_CNT;
            next_address = `IRVM_WADDR_CNT;
        end else if (pend_pit) begin
            next_vector  = `IRVM_VEC_PIT;
            next_address = `IRVM_WADDR_PIT;
        end else begin
            next_req = 1'b0;
        end
    end

    // Outputs to the core are registered; they drop one cycle after the
    // flag clears, which the core must allow for before re-sampling.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            core_req     <= 1'b0;
            core_nmi     <= 1'b0;
            core_vector  <= `IRVM_VEC_RESET;
            core_address <= `IRVM_WADDR_RESET;
        end else begin
            core_req     <= next_req;
            core_nmi     <= next_nmi;
            core_vector  <= next_vector;
            core_address <= next_address;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            taken_vector <= `IRVM_VEC_RESET;
        end else if (core_vector_ack && core_req) begin
            taken_vector <= core_vector;
        end
    end

endmodule : irvm_controller

// >>> bench/irvm_properties.sv
`include "irvm_regs.svh"

module irvm_properties (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rstn,
    // Register bus
    input wire logic [`IRVM_ADDR_W-1:0] avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_writedata,
    input wire logic [3:0]              avs_byteenable,
    input wire logic                    avs_waitrequest,
    // Events
    input wire logic                    memory_scan_nmi_source,
    input wire logic                    voltage_level_monitor_source,
    input wire logic [1:0]              counter_overflow_compare_source,
    input wire logic                    periodic_timer_source,
    // Core side
    input wire logic                    core_req,
    input wire logic                    core_nmi,
    input wire logic [`IRVM_VEC_W-1:0]  core_vector,
    input wire logic [7:0]              core_address,
    input wire logic                    irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic                  gie;
    logic [`IRVM_NSRC-1:0] en_sh;
    wire  acc_wr = avs_write & ~avs_waitrequest;
    wire  ev     = memory_scan_nmi_source | voltage_level_monitor_source |
                   (|counter_overflow_compare_source) | periodic_timer_source;

    // Shadow of the global enable, so its effect can be judged from the ports alone.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            gie <= 1'b0;
        end else if (acc_wr && avs_address == `IRVM_OFS_GLOBAL && avs_byteenable[0]) begin
            gie <= avs_writedata[`IRVM_BIT_GIE];
        end
    end

    // Shadow of the source enables, since an event on a disabled source must not request.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            en_sh <= '0;
        end else if (acc_wr && avs_address == `IRVM_OFS_ENABLE && avs_byteenable[0]) begin
            en_sh <= avs_writedata[`IRVM_NSRC-1:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_nmi_shown;
        ##2 core_req && core_nmi && core_address == `IRVM_WADDR_NMI;
    endsequence

    AST_BUS: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_answer)
        else $error("bus access not answered in one cycle");
    AST_NMI_EVT: assert property (memory_scan_nmi_source && en_sh[`IRVM_BIT_NMI] && !acc_wr |-> s_nmi_shown)
        else $error("memory scan event not presented as vector 1");
    AST_ADDR: assert property (core_address == {4'h0, core_vector, 1'b0})
        else $error("word address does not match vector");
    AST_NMI_VEC: assert property (core_nmi == (core_vector == `IRVM_VEC_NMI))
        else $error("nmi flag does not match vector");
    AST_IDLE: assert property (core_req == (core_vector != `IRVM_VEC_RESET))
        else $error("request and vector disagree");
    AST_GIE: assert property (core_req && !core_nmi |-> $past(gie))
        else $error("maskable request without global enable");
    AST_REQ_HOLD: assert property ($fell(core_req) |-> $past(acc_wr, 2))
        else $error("request dropped without a register write");
    AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(acc_wr, 2))
        else $error("irq dropped without a register write");
    AST_REQ_RISE: assert property ($rose(core_req) |-> $past(ev || acc_wr, 2))
        else $error("request rose without a cause");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(ev || acc_wr, 2))
        else $error("irq rose without a cause");
endmodule : irvm_properties

bind irvm_controller irvm_properties irvm_properties_inst (
    .sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .memory_scan_nmi_source, .voltage_level_monitor_source,
    .counter_overflow_compare_source, .periodic_timer_source, .core_req, .core_nmi,
    .core_vector, .core_address, .irq
);

// >>> bench/irvm_core_model.sv
// Processor core stand-in: acknowledges a presented vector after a set delay.
module irvm_core_model (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // Vector fetch
    input wire logic       core_req,
    input wire logic [7:0] ack_delay,
    output logic           core_vector_ack
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] wait_cnt;

    // A delay of zero models a core with interrupts masked that never fetches.
    always_ff @(posedge sys_clk) begin
        core_vector_ack <= 1'b0;
        if (!rstn || !core_req || ack_delay == 8'h00) begin
            wait_cnt <= 8'h00;
        end else if (wait_cnt + 8'h01 >= ack_delay) begin
            core_vector_ack <= 1'b1;
            wait_cnt        <= 8'h00;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule : irvm_core_model

// >>> bench/interrupt_request_vector_map_test.sv
`include "irvm_regs.svh"

module interrupt_request_vector_map_test;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic       g;
        logic [4:0] en;
        logic [4:0] ev;
        logic [2:0] v;
    } irvm_row_t;

    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [4:0]  ev_drive = 5'h00;
    logic        memory_scan_nmi_source;
    logic        voltage_level_monitor_source;
    logic [1:0]  counter_overflow_compare_source;
    logic        periodic_timer_source;
    logic        core_vector_ack;
    logic        core_req;
    logic        core_nmi;
    logic [2:0]  core_vector;
    logic [7:0]  core_address;
    logic        irq;
    logic [7:0]  ack_delay = 8'h01;
    logic [31:0] rd;
    int          mismatches = 0;
    int          check_count = 0;
    irvm_row_t   rows[9] = '{'{1'h1, 5'h1f, 5'h02, 3'h2}, '{1'h1, 5'h1f, 5'h04, 3'h3},
        '{1'h1, 5'h1f, 5'h08, 3'h3}, '{1'h1, 5'h1f, 5'h10, 3'h4}, '{1'h0, 5'h1f, 5'h1e, 3'h0},
        '{1'h0, 5'h01, 5'h01, 3'h1}, '{1'h1, 5'h1d, 5'h12, 3'h4}, '{1'h1, 5'h1f, 5'h1f, 3'h1},
        '{1'h1, 5'h1f, 5'h1c, 3'h3}};

    assign {periodic_timer_source, counter_overflow_compare_source, voltage_level_monitor_source,
            memory_scan_nmi_source} = ev_drive;

    always #2.5 sys_clk = ~sys_clk;

    irvm_controller irvm_controller_inst (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .memory_scan_nmi_source,
        .voltage_level_monitor_source, .counter_overflow_compare_source, .periodic_timer_source,
        .core_vector_ack, .core_req, .core_nmi, .core_vector, .core_address, .irq);
    irvm_core_model irvm_core_model_inst (.sys_clk, .rstn, .core_req, .ack_delay, .core_vector_ack);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One idle cycle follows every access, so no strobe is driven twice in one step.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic pulse(input logic [4:0] s);
        ev_drive <= s;
        @(posedge sys_clk);
        ev_drive <= 5'h00;
        repeat (3) @(posedge sys_clk);
    endtask : pulse

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("ERROR at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check(avs_waitrequest, 1'b1);
        check(core_req, 1'b0);
        check(irq, 1'b0);
        bus(1'b1, 6'h3c, 32'hffffffff);
        for (int a = 0; a < 8; a++) begin
            bus(1'b0, 6'(a * 4), 32'h0);
            check(rd, 32'h0);
        end
        foreach (rows[i]) begin
            bus(1'b1, `IRVM_OFS_GLOBAL, {31'h0, rows[i].g});
            bus(1'b1, `IRVM_OFS_ENABLE, {27'h0, rows[i].en});
            bus(1'b1, `IRVM_OFS_MASK, {27'h0, rows[i].en});
            pulse(rows[i].ev);
            check(core_vector, rows[i].v);
            check(core_address, {4'h0, rows[i].v, 1'b0});
            check(core_req, rows[i].v != 3'h0);
            check(core_nmi, rows[i].v == 3'h1);
            check(irq, |(rows[i].ev & rows[i].en));
            bus(1'b0, `IRVM_OFS_FLAGS, 32'h0);
            check(rd, {27'h0, rows[i].ev});
            bus(1'b0, `IRVM_OFS_VECTOR, 32'h0);
            check(rd, {14'h0, rows[i].v == 3'h1, rows[i].v != 3'h0, 4'h0, rows[i].v, 6'h0, rows[i].v});
            bus(1'b1, `IRVM_OFS_FLAGS, 32'h1f);
            repeat (2) @(posedge sys_clk);
            check(core_req, 1'b0);
        end
        bus(1'b1, `IRVM_OFS_GLOBAL, 32'h1);
        ack_delay <= 8'h07;
        pulse(5'h06);
        repeat (40) @(posedge sys_clk);
        check(core_vector, 3'h2);
        bus(1'b0, `IRVM_OFS_TAKEN, 32'h0);
        check(rd, 32'h2);
        bus(1'b1, `IRVM_OFS_GLOBAL, 32'h0);
        repeat (2) @(posedge sys_clk);
        check(core_req, 1'b0);
        bus(1'b1, `IRVM_OFS_GLOBAL, 32'h1);
        bus(1'b1, `IRVM_OFS_FLAGS, 32'h2);
        repeat (2) @(posedge sys_clk);
        check(core_vector, 3'h3);
        avs_byteenable <= 4'he;
        bus(1'b1, `IRVM_OFS_ENABLE, 32'h0);
        repeat (2) @(posedge sys_clk);
        check(core_vector, 3'h3);
        avs_byteenable <= 4'hf;
        bus(1'b1, `IRVM_OFS_ENABLE, 32'h1b);
        repeat (2) @(posedge sys_clk);
        check(core_req, 1'b0);
        pulse(5'h01);
        check(core_nmi, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, `IRVM_OFS_FLAGS, 32'h0);
        check(rd, 32'h0);
        check(core_req, 1'b0);
        report_and_stop();
    end
endmodule : interrupt_request_vector_map_test
